// [core/rsso_alu.sv]
`timescale 1ns/1ps
`default_nettype none

module rsso_alu
  import rsso_pkg::*;
(
  // Operation
  input  wire rsso_op_t   op,
  // Operands
  input  wire logic [7:0] file_val,
  input  wire logic [7:0] acc_val,
  input  wire logic [7:0] literal,
  input  wire logic       carry_in,
  // Results
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            nibble_out,
  output logic            zero_out
);

  function automatic logic no_borrow(input logic [7:0] minuend, input logic [7:0] subtrahend);
    no_borrow = (subtrahend <= minuend);
  endfunction

  always_comb begin
    result     = acc_val;
    carry_out  = carry_in;
    nibble_out = 1'b0;
    zero_out   = 1'b0;
    unique case (op)
      RSSO_OP_ROT_LEFT: begin
        result    = {file_val[6:0], carry_in};
        carry_out = file_val[7];
      end
      RSSO_OP_ROT_RIGHT: begin
        result    = {carry_in, file_val[7:1]};
        carry_out = file_val[0];
      end
      RSSO_OP_LIT_MINUS_ACC: begin
        result     = literal - acc_val;
        carry_out  = no_borrow(literal, acc_val);
        nibble_out = no_borrow({4'h0, literal[3:0]}, {4'h0, acc_val[3:0]});
        zero_out   = (literal == acc_val);
      end
      default: begin
        result    = acc_val;
        carry_out = carry_in;
      end
    endcase
  end

endmodule

`default_nettype wire

// [core/rsso_core.sv]
`include "rsso_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rsso_core
  import rsso_pkg::*;
#(
  parameter int FILE_DEPTH = `RSSO_FILE_DEPTH,
  parameter int PRESC_W    = `RSSO_PRESC_W,
  parameter int WDOG_W     = `RSSO_WDOG_W
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Wake request from outside the core
  input  wire logic        wake_req,
  // Status outputs
  output logic             osc_run,
  output logic             irq
);

  localparam int FA_W = $clog2(FILE_DEPTH);

  // File register storage
  logic [7:0]         file_mem [FILE_DEPTH];
  logic               mem_we;
  logic [FA_W-1:0]    mem_waddr;
  logic [7:0]         mem_wdata;

  // Architectural state
  rsso_state_t        state_q;
  rsso_state_t        state_d;
  logic [7:0]         acc_q;
  logic [7:0]         acc_d;
  logic               carry_q;
  logic               carry_d;
  logic               nibble_q;
  logic               nibble_d;
  logic               zero_q;
  logic               zero_d;
  logic               pwrdn_q;
  logic               pwrdn_d;
  logic               expiry_q;
  logic               expiry_d;
  logic [`RSSO_CMD_W-1:0] cmd_q;
  logic [`RSSO_CMD_W-1:0] cmd_d;
  logic [FA_W-1:0]    fptr_q;
  logic [FA_W-1:0]    fptr_d;

  // Watchdog
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic [WDOG_W-1:0]  wdog_q;
  logic [WDOG_W-1:0]  wdog_d;
  logic               wdog_en_q;
  logic               wdog_en_d;
  logic               wdog_tick;
  logic               wdog_ovf;

  // Interrupts
  logic [`RSSO_EV_W-1:0] irq_stat_q;
  logic [`RSSO_EV_W-1:0] irq_stat_d;
  logic [`RSSO_EV_W-1:0] irq_mask_q;
  logic [`RSSO_EV_W-1:0] irq_mask_d;
  logic [`RSSO_EV_W-1:0] events;
  logic               irq_q;
  logic               irq_d;

  // Bus
  logic [31:0]        prdata_q;
  logic [31:0]        prdata_d;
  logic               pslverr_q;
  logic               pslverr_d;
  logic               osc_run_q;
  logic               osc_run_d;
  logic               bus_setup;
  logic               bus_wr;

  // Command decode
  rsso_op_t           cmd_op;
  logic               cmd_dest;
  logic [FA_W-1:0]    cmd_fa;
  logic [7:0]         cmd_lit;
  logic               cmd_go;

  // Datapath results
  logic [7:0]         alu_result;
  logic               alu_carry;
  logic               alu_nibble;
  logic               alu_zero;

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == `RSSO_OFF_CMD)      || (addr == `RSSO_OFF_ACC)      ||
                  (addr == `RSSO_OFF_FLAGS)    || (addr == `RSSO_OFF_FPTR)     ||
                  (addr == `RSSO_OFF_FDATA)    || (addr == `RSSO_OFF_WDOG)     ||
                  (addr == `RSSO_OFF_IRQ_STAT) || (addr == `RSSO_OFF_IRQ_MASK) ||
                  (addr == `RSSO_OFF_CTRL);
  endfunction

  function automatic logic [31:0] flags_word(input logic c, input logic nib, input logic z,
                                             input logic down, input logic expd, input logic slp);
    flags_word = 32'h0000_0000;
    flags_word[`RSSO_FLG_C]      = c;
    flags_word[`RSSO_FLG_NIB]    = nib;
    flags_word[`RSSO_FLG_Z]      = z;
    flags_word[`RSSO_FLG_PWRDN]  = down;
    flags_word[`RSSO_FLG_EXPIRY] = expd;
    flags_word[`RSSO_FLG_SLEEP] = slp;
  endfunction

  assign bus_setup = psel & ~penable;
  assign bus_wr    = psel & penable & pwrite;

  // Command fields come straight off the write data
  assign cmd_op   = rsso_op_t'(pwdata[`RSSO_CMD_OP_LSB +: `RSSO_CMD_OP_W]);
  assign cmd_dest = pwdata[`RSSO_CMD_DEST_BIT];
  assign cmd_fa   = pwdata[`RSSO_CMD_FA_LSB +: FA_W];
  assign cmd_lit  = pwdata[`RSSO_CMD_LIT_LSB +: 8];
  // Commands are dropped while asleep: only a wake source restarts the core
  assign cmd_go   = bus_wr && (paddr == `RSSO_OFF_CMD) && (state_q == RSSO_RUN);

  rsso_alu u_alu (
    .op         (cmd_op),
    .file_val   (file_mem[cmd_fa]),
    .acc_val    (acc_q),
    .literal    (cmd_lit),
    .carry_in   (carry_q),
    .result     (alu_result),
    .carry_out  (alu_carry),
    .nibble_out (alu_nibble),
    .zero_out   (alu_zero)
  );

  // Watchdog keeps counting in sleep; it ticks from pclk through the prescaler
  assign wdog_tick = wdog_en_q & (&presc_q);
  assign wdog_ovf  = wdog_tick & (&wdog_q);

  always_comb begin
    state_d    = state_q;
    acc_d      = acc_q;
    carry_d    = carry_q;
    nibble_d   = nibble_q;
    zero_d     = zero_q;
    pwrdn_d    = pwrdn_q;
    expiry_d   = expiry_q;
    cmd_d      = cmd_q;
    fptr_d     = fptr_q;
    wdog_en_d  = wdog_en_q;
    irq_mask_d = irq_mask_q;
    mem_we     = 1'b0;
    mem_waddr  = fptr_q;
    mem_wdata  = pwdata[7:0];
    events     = '0;
    presc_d    = wdog_en_q ? presc_q + 1'b1 : presc_q;
    wdog_d     = wdog_tick ? wdog_q + 1'b1 : wdog_q;

    if (wdog_ovf) begin
      expiry_d              = 1'b0;
      events[`RSSO_EV_WDOG] = 1'b1;
    end

    if (cmd_go) begin
      cmd_d = pwdata[`RSSO_CMD_W-1:0];
      events[`RSSO_EV_DONE] = 1'b1;
      unique case (cmd_op)
        RSSO_OP_NOP: begin
          acc_d = acc_q;
        end
        RSSO_OP_ROT_LEFT, RSSO_OP_ROT_RIGHT: begin
          carry_d = alu_carry;
          if (cmd_dest) begin
            mem_we    = 1'b1;
            mem_waddr = cmd_fa;
            mem_wdata = alu_result;
          end else begin
            acc_d = alu_result;
          end
        end
        RSSO_OP_LIT_MINUS_ACC: begin
          acc_d    = alu_result;
          carry_d  = alu_carry;
          nibble_d = alu_nibble;
          zero_d   = alu_zero;
        end
        RSSO_OP_SLEEP: begin
          pwrdn_d  = 1'b0;
          expiry_d = 1'b1;
          wdog_d   = WDOG_W'(`RSSO_WDOG_CLR);
          presc_d  = '0;
          state_d  = RSSO_ASLEEP;
          events[`RSSO_EV_SLEEP] = 1'b1;
        end
        default: begin
          events[`RSSO_EV_DONE]   = 1'b0;
          events[`RSSO_EV_BADCMD] = 1'b1;
        end
      endcase
    end else if (bus_wr) begin
      unique case (paddr)
        `RSSO_OFF_ACC: acc_d = pwdata[7:0];
        `RSSO_OFF_FLAGS: begin
          carry_d  = pwdata[`RSSO_FLG_C];
          nibble_d = pwdata[`RSSO_FLG_NIB];
          zero_d   = pwdata[`RSSO_FLG_Z];
        end
        `RSSO_OFF_FPTR: fptr_d = pwdata[FA_W-1:0];
        `RSSO_OFF_FDATA: mem_we = 1'b1;
        `RSSO_OFF_IRQ_MASK: irq_mask_d = pwdata[`RSSO_EV_W-1:0];
        `RSSO_OFF_CTRL: wdog_en_d = pwdata[0];
        default: acc_d = acc_q;
      endcase
    end

    // Halt lasts until a wake request or a watchdog expiry
    if ((state_q == RSSO_ASLEEP) && (wake_req || wdog_ovf)) begin
      state_d = RSSO_RUN;
      events[`RSSO_EV_WAKE] = 1'b1;
    end

    // New events win over a write-one clear in the same cycle
    irq_stat_d = irq_stat_q;
    if (bus_wr && (paddr == `RSSO_OFF_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~pwdata[`RSSO_EV_W-1:0];
    end
    irq_stat_d = irq_stat_d | events;
    irq_d      = |(irq_stat_d & irq_mask_d);
    osc_run_d  = (state_d == RSSO_RUN);
  end

  // Read data is captured in the setup phase so the access phase answers at once
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (bus_setup) begin
      pslverr_d = ~addr_mapped(paddr);
      unique case (paddr)
        `RSSO_OFF_CMD:      prdata_d = {{(32-`RSSO_CMD_W){1'b0}}, cmd_q};
        `RSSO_OFF_ACC:      prdata_d = {24'h00_0000, acc_q};
        `RSSO_OFF_FLAGS:    prdata_d = flags_word(carry_q, nibble_q, zero_q, pwrdn_q, expiry_q,
                                                  state_q == RSSO_ASLEEP);
        `RSSO_OFF_FPTR:     prdata_d = {{(32-FA_W){1'b0}}, fptr_q};
        `RSSO_OFF_FDATA:    prdata_d = {24'h00_0000, file_mem[fptr_q]};
        `RSSO_OFF_WDOG:     prdata_d = {{(16-PRESC_W){1'b0}}, presc_q,
                                        {(16-WDOG_W){1'b0}}, wdog_q};
        `RSSO_OFF_IRQ_STAT: prdata_d = {{(32-`RSSO_EV_W){1'b0}}, irq_stat_q};
        `RSSO_OFF_IRQ_MASK: prdata_d = {{(32-`RSSO_EV_W){1'b0}}, irq_mask_q};
        `RSSO_OFF_CTRL:     prdata_d = {31'h0000_0000, wdog_en_q};
        default:            prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= RSSO_RUN;
      acc_q      <= 8'h00;
      carry_q    <= 1'b0;
      nibble_q   <= 1'b0;
      zero_q     <= 1'b0;
      pwrdn_q    <= `RSSO_PWRDN_RST;
      expiry_q   <= `RSSO_EXPIRY_RST;
      cmd_q      <= '0;
      fptr_q     <= '0;
      presc_q    <= '0;
      wdog_q     <= '0;
      wdog_en_q  <= `RSSO_WDOG_EN_RST;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
      osc_run_q  <= 1'b1;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      acc_q      <= acc_d;
      carry_q    <= carry_d;
      nibble_q   <= nibble_d;
      zero_q     <= zero_d;
      pwrdn_q    <= pwrdn_d;
      expiry_q   <= expiry_d;
      cmd_q      <= cmd_d;
      fptr_q     <= fptr_d;
      presc_q    <= presc_d;
      wdog_q     <= wdog_d;
      wdog_en_q  <= wdog_en_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q      <= irq_d;
      osc_run_q  <= osc_run_d;
      prdata_q   <= prdata_d;
      pslverr_q  <= pslverr_d;
    end
  end

  // File registers hold no reset value, like ordinary data memory
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      file_mem[mem_waddr] <= mem_wdata;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & psel & penable;
  assign pready  = 1'b1;
  assign osc_run = osc_run_q;
  assign irq     = irq_q;

endmodule

`default_nettype wire

// [core/rsso_params.svh]
`ifndef RSSO_PARAMS_SVH
`define RSSO_PARAMS_SVH

// Register byte offsets
`define RSSO_OFF_CMD       8'h00
`define RSSO_OFF_ACC       8'h04
`define RSSO_OFF_FLAGS     8'h08
`define RSSO_OFF_FPTR      8'h0c
`define RSSO_OFF_FDATA     8'h10
`define RSSO_OFF_WDOG      8'h14
`define RSSO_OFF_IRQ_STAT  8'h18
`define RSSO_OFF_IRQ_MASK  8'h1c
`define RSSO_OFF_CTRL      8'h20

// Command word fields
`define RSSO_CMD_OP_LSB    0
`define RSSO_CMD_OP_W      3
`define RSSO_CMD_DEST_BIT  3
`define RSSO_CMD_FA_LSB    4
`define RSSO_CMD_LIT_LSB   16
`define RSSO_CMD_W         24

// Flag register bit positions
`define RSSO_FLG_C         0
`define RSSO_FLG_NIB       1
`define RSSO_FLG_Z         2
`define RSSO_FLG_PWRDN     3
`define RSSO_FLG_EXPIRY    4
`define RSSO_FLG_SLEEP     5

// Interrupt event bit positions
`define RSSO_EV_DONE       0
`define RSSO_EV_SLEEP      1
`define RSSO_EV_WAKE       2
`define RSSO_EV_WDOG       3
`define RSSO_EV_BADCMD     4
`define RSSO_EV_W          5

// Reset values and sizes
`define RSSO_PWRDN_RST     1'b1
`define RSSO_EXPIRY_RST    1'b1
`define RSSO_WDOG_EN_RST   1'b0
`define RSSO_WDOG_CLR      8'h00
`define RSSO_FILE_DEPTH    128
`define RSSO_PRESC_W       8
`define RSSO_WDOG_W        8

`endif

// [core/rsso_pkg.sv]
package rsso_pkg;

  typedef enum logic [2:0] {
    RSSO_OP_NOP,
    RSSO_OP_ROT_LEFT,
    RSSO_OP_ROT_RIGHT,
    RSSO_OP_LIT_MINUS_ACC,
    RSSO_OP_SLEEP
  } rsso_op_t;

  typedef enum logic {
    RSSO_RUN,
    RSSO_ASLEEP
  } rsso_state_t;

endpackage

// [sim/rsso_core_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module rsso_core_assertions #(
  parameter int FILE_DEPTH = 128,
  parameter int PRESC_W    = 8,
  parameter int WDOG_W     = 8
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status
  input wire logic        wake_req,
  input wire logic        osc_run,
  input wire logic        irq
);
  logic       acc_ph;
  logic       sleep_wr;
  logic       slept_q;
  logic       slept_d;
  logic [3:0] since_q;
  logic [3:0] since_d;

  assign acc_ph   = psel && penable;
  assign sleep_wr = acc_ph && pwrite && paddr == 8'h00 && pwdata[2:0] == 3'h4 && osc_run;

  // Saturating age of the last sleep; short windows only, before any watchdog tick
  always_comb begin
    slept_d = slept_q | sleep_wr;
    since_d = sleep_wr ? 4'h0 : (since_q == 4'hf) ? since_q : since_q + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slept_q <= 1'b0;
      since_q <= 4'hf;
    end else begin
      slept_q <= slept_d;
      since_q <= since_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sleep_cmd;
    sleep_wr;
  endsequence
  sequence s_flags_rd;
    acc_ph && !pwrite && paddr == 8'h08;
  endsequence
  sequence s_wdog_rd;
    acc_ph && !pwrite && paddr == 8'h14;
  endsequence

  a_sleep_stops_osc: assert property (s_sleep_cmd |-> ##[1:2] !osc_run)
    else $error("oscillator still running after sleep");
  a_wake_restarts: assert property (!osc_run && wake_req |-> ##[1:2] osc_run)
    else $error("oscillator not restarted by wake");
  a_powerdown_cleared: assert property (s_flags_rd and slept_q |-> !prdata[3])
    else $error("powerdown bit set after sleep");
  a_expiry_set: assert property (s_flags_rd and since_q < 4'h8 |-> prdata[4])
    else $error("expiry bit clear right after sleep");
  a_wdog_cleared: assert property (s_wdog_rd and since_q <= 4'h3 |->
    prdata[7:0] == 8'h00 && prdata[23:16] < {4'h0, since_q})
    else $error("watchdog not cleared by sleep");
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_irq_masked: assert property (acc_ph && pwrite && paddr == 8'h1c && pwdata[4:0] == 5'h00
    |-> ##2 !irq)
    else $error("irq high with all events masked");
  a_err_unmapped: assert property (acc_ph && paddr[1:0] == 2'b00 |->
    pslverr == (paddr > 8'h20))
    else $error("pslverr does not match the address map");
endmodule

bind rsso_core rsso_core_assertions #(
  .FILE_DEPTH(FILE_DEPTH), .PRESC_W(PRESC_W), .WDOG_W(WDOG_W)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .wake_req(wake_req),
  .osc_run(osc_run), .irq(irq)
);

`default_nettype wire

// [sim/rsso_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rsso_params.svh"

module rsso_core_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wake_req;
  logic        osc_run;
  logic        irq;
  logic        rd_valid;
  logic        rd_err;
  logic [31:0] rd_data;
  logic [32:0] exp_q[$];
  string       nam_q[$];
  int          mismatches;
  int          checked;
  int          n;
  logic [31:0] rnd;
  logic [7:0]  a, k, f, r, acc;
  logic [6:0]  p;
  logic [2:0]  fl, op;
  logic        d;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Short watchdog widths so an overflow wake fits in a few dozen cycles
  rsso_core #(.PRESC_W(2), .WDOG_W(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_req(wake_req),
    .osc_run(osc_run), .irq(irq)
  );

  rsso_decoder_model u_dec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid),
    .rd_err(rd_err), .rd_data(rd_data)
  );

  function automatic logic [31:0] nx(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    for (int i = 0; i < 32; i++)
      v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    u_dec.xfer(1'b1, ad, dt);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [32:0] e, input string nm);
    exp_q.push_back(e);
    nam_q.push_back(nm);
    u_dec.xfer(1'b0, ad, 32'h0);
  endtask

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Each completed read takes the oldest note
  always @(posedge pclk) begin
    if (rd_valid === 1'b1) begin
      chk(nam_q.pop_front(), exp_q.pop_front(), {rd_err, rd_data});
    end
  end

  initial begin
    #100000;
    mismatches++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    wake_req = 1'b0;
    mismatches = 0;
    checked = 0;
    rnd = 32'he793;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RSSO_OFF_FLAGS, 33'h18, "flags_rst");
    rd(`RSSO_OFF_IRQ_MASK, 33'h0, "mask_rst");
    rd(8'h24, {1'b1, 32'h0}, "unmapped");
    for (int i = 0; i < 6; i++) begin
      for (int s = 0; s < 5; s++) begin
        rnd = nx(rnd);
        a = rnd[7:0];
        k = (i == 0) ? a : rnd[15:8];
        f = rnd[23:16];
        p = rnd[30:24];
        rnd = nx(rnd);
        fl = rnd[2:0];
        op = (s < 2) ? 3'h1 : (s < 4) ? 3'h2 : 3'h3;
        d = s[0] && (s < 4);
        wr(`RSSO_OFF_ACC, {24'h0, a});
        wr(`RSSO_OFF_FLAGS, {29'h0, fl});
        wr(`RSSO_OFF_FPTR, {25'h0, p});
        wr(`RSSO_OFF_FDATA, {24'h0, f});
        wr(`RSSO_OFF_CMD, {8'h0, k, 5'h0, p, d, op});
        case (op)
          3'h1: {fl[0], r} = {f, fl[0]};
          3'h2: {r, fl[0]} = {fl[0], f};
          default: begin
            r = k - a;
            fl = {r == 8'h00, a[3:0] <= k[3:0], a <= k};
          end
        endcase
        acc = d ? a : r;
        rd(`RSSO_OFF_ACC, {25'h0, acc}, "acc");
        rd(`RSSO_OFF_FDATA, {25'h0, d ? r : f}, "file");
        rd(`RSSO_OFF_FLAGS, {27'h0, 3'h3, fl}, "flags");
      end
    end
    for (int o = 5; o < 8; o++) begin
      wr(`RSSO_OFF_IRQ_STAT, 32'h1f);
      wr(`RSSO_OFF_CMD, 32'(o));
      rd(`RSSO_OFF_IRQ_STAT, 33'h10, "badcmd");
      rd(`RSSO_OFF_ACC, {25'h0, acc}, "acc_kept");
    end
    // No-operation command: recorded as the last command, accumulator untouched
    wr(`RSSO_OFF_CMD, 32'h0);
    rd(`RSSO_OFF_CMD, 33'h0, "cmd_nop");
    rd(`RSSO_OFF_ACC, {25'h0, acc}, "acc_nop");
    wr(`RSSO_OFF_IRQ_MASK, 32'h0);
    wr(`RSSO_OFF_IRQ_STAT, 32'h1f);
    wr(`RSSO_OFF_CMD, {8'h0, acc, 13'h0, 3'h3});
    acc = 8'h00;
    fl = 3'h7;
    @(negedge pclk);
    chk("irq_masked", 33'h0, {32'h0, irq});
    rd(`RSSO_OFF_IRQ_STAT, 33'h1, "done_ev");
    wr(`RSSO_OFF_IRQ_MASK, 32'h1);
    @(negedge pclk);
    chk("irq_on", 33'h1, {32'h0, irq});
    wr(`RSSO_OFF_IRQ_STAT, 32'h1);
    @(negedge pclk);
    chk("irq_off", 33'h0, {32'h0, irq});
    // Run the watchdog a while, then freeze it so the clear on sleep is visible
    wr(`RSSO_OFF_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    wr(`RSSO_OFF_CTRL, 32'h0);
    wr(`RSSO_OFF_CMD, 32'h4);
    @(negedge pclk);
    chk("osc_sleep", 33'h0, {32'h0, osc_run});
    rd(`RSSO_OFF_WDOG, 33'h0, "wdog_clr");
    rd(`RSSO_OFF_FLAGS, {27'h0, 3'h6, fl}, "flags_sleep");
    wr(`RSSO_OFF_CMD, {8'h0, 8'h55, 16'h3});
    rd(`RSSO_OFF_ACC, {25'h0, acc}, "acc_asleep");
    @(posedge pclk);
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk("osc_wake", 33'h1, {32'h0, osc_run});
    rd(`RSSO_OFF_IRQ_STAT, 33'h7, "sleep_wake_ev");
    wr(`RSSO_OFF_CTRL, 32'h1);
    wr(`RSSO_OFF_CMD, 32'h4);
    @(negedge pclk);
    for (n = 0; n < 300 && osc_run !== 1'b1; n++)
      @(posedge pclk);
    chk("wdog_wake", 33'h1, {32'h0, osc_run});
    rd(`RSSO_OFF_FLAGS, {30'h0, fl}, "flags_expired");
    rd(`RSSO_OFF_IRQ_STAT, 33'hf, "wdog_ev");
    wr(`RSSO_OFF_CTRL, 32'h0);
    test_done();
  end
endmodule

`default_nettype wire

// [sim/rsso_decoder_model.sv]
`timescale 1ns/1ps
`default_nettype none

module rsso_decoder_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB requester side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Read results
  output logic             rd_valid,
  output logic             rd_err,
  output logic      [31:0] rd_data
);
  initial begin
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    rd_valid = 1'b0;
    rd_err   = 1'b0;
    rd_data  = 32'h0;
  end

  // Released lines flip so a stale address or data is never mistaken for a live one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_valid <= !w;
    rd_err   <= pslverr;
    rd_data  <= prdata;
    psel     <= 1'b0;
    penable  <= 1'b0;
    paddr    <= ~a;
    pwdata   <= ~d;
    @(posedge pclk);
    rd_valid <= 1'b0;
  endtask
endmodule

`default_nettype wire
